/* File: dv/cldc_mem_model.sv */
// Memory partner model for the channel memory port
`timescale 1ns/1ps
module cldc_mem_model
   import cldc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire cldc_mem_t i_mem,
   output logic o_ack,
   output logic [CLDC_DW-1:0] o_rdata
);
   logic [CLDC_DW-1:0] mem [0:1023]; // Backing store, low address bits only
   logic [1:0] wait_cnt; // Cycles spent on the current request
   logic slow; // Alternates prompt and slow answers
   logic last_par; // Parity bit of the last write
   int cycles; // Completed memory cycles
   int writes; // Completed writes
   logic [CLDC_AW-1:0] reads [$]; // Read addresses in issue order

   //////////////////////////////////////////////////////////////////////
   // One access at a time; ack is a single cycle pulse
   always @(posedge i_clk_sys) begin
      o_ack <= 1'h0;
      // Unanswered data keeps toggling so stale words never look valid
      o_rdata <= i_reset ? '0 : ~o_rdata;
      if (i_reset || !i_mem.req) begin
         wait_cnt <= 2'h0;
      end else if (!o_ack && wait_cnt == {slow, 1'h1}) begin
         o_ack <= 1'h1;
         wait_cnt <= 2'h0;
         slow <= ~slow;
         cycles++;
         if (i_mem.we) begin
            mem[i_mem.addr[9:0]] <= i_mem.wdata;
            last_par <= i_mem.par;
            writes++;
         end else begin
            o_rdata <= mem[i_mem.addr[9:0]];
            reads.push_back(i_mem.addr);
         end
      end else if (!o_ack) begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
   initial slow = 1'h0;
endmodule : cldc_mem_model

/* File: dv/command_list_data_channel_bench.sv */
// Self-checking bench for the command list data channel
`timescale 1ns/1ps
module command_list_data_channel_bench
   import cldc_pkg::*;
;
   localparam int DCLR = 20; // Short delayed clear keeps the run brief
   localparam logic [CLDC_DW-1:0] W1 = 36'h1_2345_6789;
   localparam logic [CLDC_DW-1:0] W2 = 36'h8_7654_3210;
   localparam logic [CLDC_AW-1:0] EXP_RD [7] = '{18'h0_0010, 18'h0_0020,
      18'h0_0101, 18'h0_0102, 18'h0_0021, 18'h0_0000, 18'h0_0022};
   logic i_clk_sys; // System clock
   logic i_reset; // Synchronous reset
   logic [2:0] reg_addr; // Register index
   logic [CLDC_RW-1:0] reg_wdata; // Register write data
   logic reg_wr; // Write strobe
   logic reg_rd; // Read strobe
   logic [CLDC_RW-1:0] reg_rdata; // Read data
   logic [3:0] dev_req; // Controller requests
   logic [3:0] grant; // One-hot grant
   logic engaged; // Channel held by a controller
   logic idle; // Channel idle
   logic stop; // Stop pulse
   logic [CLDC_DW-1:0] data_bus; // Controller data bus
   logic strobe; // Device pulse
   logic m2d; // Memory to device direction
   logic force_even; // Even parity request
   logic [CLDC_DW-1:0] dev_word; // Outbound word
   logic dev_word_valid; // Outbound word pulse
   cldc_mem_t mem_bus; // Memory request bundle
   logic mem_ack; // Memory answer
   logic [CLDC_DW-1:0] mem_rdata; // Memory read data
   int mismatches; // Failed comparisons
   int tests_run; // Comparisons made
   int stops; // Stop pulses seen
   int c0; // Counter mark
   int c1; // Second counter mark
   logic [CLDC_DW-1:0] words [$]; // Outbound words seen
   logic [CLDC_RW-1:0] v; // Last register read

   cldc_channel #(.NCTL(4), .DCLR_CNT(DCLR)) dut (.i_clk_sys(i_clk_sys),
      .i_reset(i_reset), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .i_dev_req(dev_req), .o_grant(grant), .o_channel_engaged(engaged),
      .o_idle(idle), .o_stop(stop), .i_data_bus(data_bus),
      .i_device_strobe(strobe), .i_mem_to_dev_sel(m2d),
      .i_force_even_par(force_even), .o_dev_word(dev_word),
      .o_dev_word_valid(dev_word_valid), .o_mem(mem_bus), .i_mem_ack(mem_ack),
      .i_mem_rdata(mem_rdata));
   cldc_mem_model memory (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_mem(mem_bus), .o_ack(mem_ack), .o_rdata(mem_rdata));

   //////////////////////////////////////////////////////////////////////
   // Clock and monitors
   initial begin
      i_clk_sys = 1'h0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      if (dev_word_valid === 1'h1) words.push_back(dev_word);
      if (stop === 1'h1) stops++;
   end

   //////////////////////////////////////////////////////////////////////
   // Access tasks
   task automatic chk(input logic [CLDC_DW-1:0] got, input logic [CLDC_DW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : cyc
   task automatic wr(input logic [2:0] a, input logic [CLDC_RW-1:0] d);
      @(posedge i_clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge i_clk_sys);
      reg_wr <= 1'h0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge i_clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge i_clk_sys);
      reg_rd <= 1'h0;
      @(posedge i_clk_sys);
      v = reg_rdata;
   endtask : rd
   // Released bus shows the inverse so stale data cannot pass
   task automatic pulse(input logic [CLDC_DW-1:0] d);
      @(posedge i_clk_sys);
      data_bus <= d;
      strobe <= 1'h1;
      @(posedge i_clk_sys);
      strobe <= 1'h0;
      data_bus <= ~d;
   endtask : pulse
   // Wait for grant, drop the request, send the start address
   task automatic grab(input int k, input logic [CLDC_AW-1:0] b);
      int n;
      n = 0;
      while (grant[k] !== 1'h1 && n < 100) begin
         @(posedge i_clk_sys);
         n++;
      end
      dev_req[k] <= 1'h0;
      pulse({27'h0, b[8:1], 1'h0});
   endtask : grab
   // One device word once the channel waits for it
   task automatic word(input logic [CLDC_DW-1:0] d);
      int n;
      n = 0;
      do begin
         rd(REG_STATUS);
         n++;
      end while (v[2:0] !== 3'h6 && n < 100);
      pulse(d);
   endtask : word
   task automatic wait_stop(input int s);
      int n;
      n = 0;
      while (stops < s && n < 2000) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk(stops, s);
   endtask : wait_stop
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   //////////////////////////////////////////////////////////////////////
   // Watchdog: the tests need well under 20000 cycles
   initial begin
      #100_000;
      mismatches++;
      complete_run();
   end

   //////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, dev_req, data_bus} = '0;
      {strobe, m2d, force_even, mismatches, tests_run, stops} = '0;
      i_reset = 1'h1;
      cyc(3);
      i_reset <= 1'h0;
      rd(REG_STATUS);
      chk(v, 18'h0_0008);
      rd(3'h6);
      chk(v, 0);
      wr(REG_CTRL, 18'h0_0015);
      rd(REG_CTRL);
      chk(v, 18'h0_0015);
      wr(REG_CTRL, 18'h0_0000);
      $display("reset and register test done");
      // Jump, two word block, zero pointer read, stop
      memory.mem[16] = {18'h0_0000, 18'h0_0020};
      memory.mem[32] = {18'h3_FFFE, 18'h0_0100};
      memory.mem[33] = {18'h3_FFFF, 18'h0_0000};
      memory.mem[34] = '0;
      memory.mem[257] = W1;
      memory.mem[258] = W2;
      memory.mem[0] = 36'hF_0F0F_0F0F;
      m2d <= 1'h1;
      dev_req[2] <= 1'h1;
      grab(2, 18'h0_0010);
      dev_req[3] <= 1'h1;
      cyc(3);
      dev_req[1] <= 1'h1;
      word('0);
      chk(grant, 4'h4);
      word('0);
      word('0);
      wait_stop(1);
      chk(words.size(), 3);
      chk(words[0], W1);
      chk(words[1], W2);
      chk(words[2], 36'hF_0F0F_0F0F);
      chk(memory.reads.size(), 7);
      for (int i = 0; i < 7; i++) chk(memory.reads[i], EXP_RD[i]);
      rd(REG_CADDR);
      chk(v, 18'h0_0023);
      rd(REG_WCOUNT);
      chk(v, 18'h0_0000);
      $display("outbound list test done");
      // Inbound skip then block, without and with parity lockout
      memory.mem[48] = {18'h3_FFFF, 18'h0_0000};
      memory.mem[49] = {18'h3_FFFE, 18'h0_01FF};
      memory.mem[50] = '0;
      m2d <= 1'h0;
      force_even <= 1'h1;
      for (int lk = 0; lk < 2; lk++) begin
         memory.mem[512] = '0;
         memory.mem[513] = '0;
         wr(REG_CTRL, lk[17:0]);
         grab(lk == 0 ? 3 : 1, 18'h0_0030);
         chk(grant, lk == 0 ? 4'h8 : 4'h2);
         c0 = memory.writes;
         word(36'h5_5555_5555);
         word(W1);
         word(W2);
         wait_stop(2 + lk);
         chk(memory.writes - c0, 2);
         chk(memory.mem[512], W1);
         chk(memory.mem[513], W2);
         chk(memory.last_par, lk == 0 ? ^W2 : ~^W2);
      end
      $display("inbound and parity test done");
      // Offline single step: fetch, zero write, fetch stop word
      memory.mem[64] = {18'h3_FFFF, 18'h0_02FF};
      memory.mem[65] = '0;
      memory.mem[768] = '1;
      wr(REG_CTRL, 18'h0_000A);
      // Raised only once test mode is on, so the idle channel never grants it
      dev_req[3] <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         c0 = memory.cycles;
         wr(REG_CMD, 18'h0_0002);
         cyc(30);
         chk(memory.cycles - c0, 1);
         if (i == 0) chk(grant, 4'h1);
      end
      chk(memory.mem[768], 0);
      chk(memory.reads[$], 18'h0_0041);
      chk(memory.last_par, 1);
      // Outbound simulation, delayed clear, then halt
      wr(REG_CTRL, 18'h0_0016);
      c0 = memory.writes;
      c1 = memory.cycles;
      wr(REG_CMD, 18'h0_0002);
      rd(REG_STATUS);
      chk(v[8], 1);
      cyc(DCLR + 10);
      rd(REG_STATUS);
      chk(v[8], 0);
      chk(memory.writes - c0, 0);
      chk(memory.cycles - c1 > 4, 1);
      wr(REG_CMD, 18'h0_0004);
      cyc(20);
      c0 = memory.cycles;
      cyc(40);
      chk(memory.cycles - c0, 0);
      chk(mem_bus.req, 0);
      wr(REG_CTRL, 18'h0_0000);
      dev_req[3] <= 1'h0;
      $display("offline test done");
      // Channel waits for the start address until cleared
      wr(REG_CMD, 18'h0_0001);
      dev_req[0] <= 1'h1;
      cyc(4);
      dev_req[0] <= 1'h0;
      cyc(50);
      chk(engaged, 1);
      chk(mem_bus.req, 0);
      wr(REG_CMD, 18'h0_0001);
      cyc(2);
      chk(engaged, 0);
      chk(idle, 1);
      $display("clear test done");
      complete_run();
   end
endmodule : command_list_data_channel_bench

/* File: pkg/cldc_pkg.sv */
// Shared constants and types for the command list data channel
package cldc_pkg;

   // Data path widths
   localparam int CLDC_AW = 18;
   localparam int CLDC_DW = 36;
   localparam int CLDC_RW = 18;

   // Register indices on the plain register port
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_CMD = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_CADDR = 3'h3;
   localparam logic [2:0] REG_WCOUNT = 3'h4;
   localparam logic [2:0] REG_XPTR = 3'h5;

   // Control register field positions (maintenance switches)
   localparam int CB_LOCKOUT = 0;
   localparam int CB_OFFLINE = 1;
   localparam int CB_SIM_OUT = 2;
   localparam int CB_SSTEP = 3;
   localparam int CB_DCLR_EN = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

   // Command register bits (pushbuttons, write one to press)
   localparam int KB_CLEAR = 0;
   localparam int KB_START = 1;
   localparam int KB_HALT = 2;

   // Initial command address forced in test mode (octal 100)
   localparam logic [CLDC_AW-1:0] TEST_INIT_ADDR = 18'h0_0040;
   localparam logic [CLDC_AW-1:0] ADDR_ONE = 18'h0_0001;
   localparam logic [CLDC_AW-1:0] ADDR_ZERO = 18'h0_0000;

   // Delayed clear time and its cycle count at the system clock
   localparam int DCLR_TIME_US = 300;
   localparam int CLK_MHZ = 200;
   localparam int DCLR_CYCLES = DCLR_TIME_US * CLK_MHZ;

   // Width of the per-controller waiting age used for arrival order;
   // a narrow age saturates and turns long waits into index ties
   localparam int AGE_W = 16;

   // Channel sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_INIT = 3'h1,
      S_FETCH = 3'h3,
      S_EVAL = 3'h2,
      S_WAITDEV = 3'h6,
      S_MEMCYC = 3'h7
   } cldc_state_t;

   // Memory port request bundle
   typedef struct packed {
      logic req;
      logic we;
      logic [CLDC_AW-1:0] addr;
      logic [CLDC_DW-1:0] wdata;
      logic par;
   } cldc_mem_t;

endpackage : cldc_pkg

/* File: rtl/cldc_channel.sv */
// Command list data channel: arbitration, list sequencer, test controls
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////
// What this block does
// - Grant oldest requester; it supplies first address
// - Holder keeps channel until list ends
// - Control word: count left, pointer right
// - Command address plus one per fetch
// - All-zero word ends, drops engaged, idle
// - Zero count, pointer set: jump there
// - Zero pointer inbound: discard device words
// - Store count, pointer; pointer plus one unless zero
// - Each word bumps count and pointer
// - Count overflow fetches next sequential word
// - Stop command signals holding controller
// - Lockout forces normal parity on writes
// - Clear button clears channel control
// - Test mode replaces bus with internals
// - Start runs; single step one cycle
// - Halt stops after current cycle
// - Simulated direction follows outbound select
// - Single step halts after each cycle
// - Delayed clear timer clears on expiry
// - Odd parity unless even requested
module cldc_channel
   import cldc_pkg::*;
#(
   parameter int NCTL = 4,
   parameter int DCLR_CNT = DCLR_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [2:0] i_reg_addr,
   input wire logic [CLDC_RW-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [CLDC_RW-1:0] o_reg_rdata,
   input wire logic [NCTL-1:0] i_dev_req,
   output logic [NCTL-1:0] o_grant,
   output logic o_channel_engaged,
   output logic o_idle,
   output logic o_stop,
   input wire logic [CLDC_DW-1:0] i_data_bus,
   input wire logic i_device_strobe,
   input wire logic i_mem_to_dev_sel,
   input wire logic i_force_even_par,
   output logic [CLDC_DW-1:0] o_dev_word,
   output logic o_dev_word_valid,
   output cldc_mem_t o_mem,
   input wire logic i_mem_ack,
   input wire logic [CLDC_DW-1:0] i_mem_rdata
);

   //////////////////////////////////////////////////////////////////
   // Declarations

   cldc_state_t state, next_state; // Sequencer state
   logic [CTRL_W-1:0] ctrl; // Maintenance switches
   logic run, next_run; // Test mode running
   logic dclr_run; // Delayed clear timer active
   logic [31:0] dclr_cnt; // Delayed clear elapsed cycles
   logic [CLDC_AW-1:0] caddr, next_caddr; // Command address
   logic [CLDC_AW-1:0] wc, next_wc; // Word count, two's complement
   logic [CLDC_AW-1:0] addr, next_addr; // Transfer pointer
   logic [CLDC_DW-1:0] cw, next_cw; // Fetched control word
   logic [CLDC_DW-1:0] data_q, next_data; // Inbound word
   logic skip, next_skip; // Discard inbound block
   logic out_q, next_out; // Block direction, memory to device
   cldc_mem_t next_mem; // Next memory request
   logic next_engaged, next_idle, next_stop;
   logic [NCTL-1:0] next_grant;
   logic [CLDC_DW-1:0] next_dword;
   logic next_dvalid;
   logic [AGE_W-1:0] age [NCTL]; // Waiting time per controller
   logic [NCTL-1:0] win_oh; // Oldest requester, one-hot
   logic [AGE_W-1:0] best_age;
   logic found;

   //////////////////////////////////////////////////////////////////
   // Register port decode and switch fields

   wire ctrl_wr = i_reg_wr && (i_reg_addr == REG_CTRL);
   wire cmd_wr = i_reg_wr && (i_reg_addr == REG_CMD);
   wire clear_btn = cmd_wr && i_reg_wdata[KB_CLEAR];
   wire start_btn = cmd_wr && i_reg_wdata[KB_START];
   wire halt_btn = cmd_wr && i_reg_wdata[KB_HALT];
   wire lockout = ctrl[CB_LOCKOUT];
   wire offline = ctrl[CB_OFFLINE];
   wire sim_out = ctrl[CB_SIM_OUT];
   wire sstep = ctrl[CB_SSTEP];
   wire dclr_en = ctrl[CB_DCLR_EN];

   // Timer expiry and button both clear the control logic
   wire dclr_exp = dclr_run && (dclr_cnt == 32'(DCLR_CNT - 1));
   wire clr = clear_btn || dclr_exp;

   //////////////////////////////////////////////////////////////////
   // Effective bus signals: test circuitry replaces the channel bus

   // Test mode: controller zero requests while running
   wire [NCTL-1:0] eff_req = offline ? NCTL'(run) : i_dev_req;
   // Test mode device pulses every cycle, data words are zero
   wire eff_strobe = offline ? 1'b1 : i_device_strobe;
   wire [CLDC_DW-1:0] eff_data = offline ? '0 : i_data_bus;
   wire eff_out = offline ? sim_out : i_mem_to_dev_sel;
   wire eff_even = offline ? 1'b0 : i_force_even_par;
   // New memory cycles wait for run in test mode
   wire go = !offline || run;
   wire mem_ack = o_mem.req && i_mem_ack;

   // Start address from bits 27..34; bits 0..26 and 35 unused
   wire [CLDC_AW-1:0] init_addr = offline ? TEST_INIT_ADDR :
      {9'h000, eff_data[8:1], 1'b0};

   //////////////////////////////////////////////////////////////////
   // Control word fields and decode

   wire [CLDC_AW-1:0] cw_wc = cw[35:18];
   wire [CLDC_AW-1:0] cw_ptr = cw[17:0];
   wire cw_stop = (cw_wc == ADDR_ZERO) && (cw_ptr == ADDR_ZERO);
   wire cw_jump = (cw_wc == ADDR_ZERO) && (cw_ptr != ADDR_ZERO);
   wire cw_zptr = (cw_ptr == ADDR_ZERO);
   wire wc_last = (wc == '1);
   // Even parity only on request and without lockout
   wire even_sel = eff_even && !lockout;
   wire wpar = even_sel ? ^data_q : ~^data_q;

   //////////////////////////////////////////////////////////////////
   // First-come-first-served: each waiting controller ages

   for (genvar g = 0; g < NCTL; g++) begin : g_age
      // Age resets when idle or granted, saturates otherwise
      always_ff @(posedge i_clk_sys) begin
         if (i_reset || !eff_req[g] || o_grant[g]) begin
            age[g] <= '0;
         end else if (age[g] != '1) begin
            age[g] <= age[g] + 1'b1;
         end
      end
   end

   // Oldest requester wins; ties go to the lower index
   always_comb begin
      win_oh = '0;
      best_age = '0;
      found = 1'b0;
      for (int i = 0; i < NCTL; i++) begin
         if (eff_req[i] && (!found || age[i] > best_age)) begin
            found = 1'b1;
            best_age = age[i];
            win_oh = '0;
            win_oh[i] = 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // Sequencer next-state logic

   always_comb begin
      next_state = state;
      next_caddr = caddr;
      next_wc = wc;
      next_addr = addr;
      next_cw = cw;
      next_data = data_q;
      next_skip = skip;
      next_out = out_q;
      next_mem = o_mem;
      next_engaged = o_channel_engaged;
      next_idle = o_idle;
      next_stop = 1'b0;
      next_grant = o_grant;
      next_dword = o_dev_word;
      next_dvalid = 1'b0;
      // A memory cycle ends on its acknowledge
      if (mem_ack) begin
         next_mem.req = 1'b0;
      end
      case (state)
         // Only an idle channel accepts a new holder
         S_IDLE: begin
            if (found) begin
               next_grant = win_oh;
               next_engaged = 1'b1;
               next_idle = 1'b0;
               next_state = S_INIT;
            end
         end
         // Waits without limit for the start address
         S_INIT: begin
            if (eff_strobe) begin
               next_caddr = init_addr;
               next_state = S_FETCH;
            end
         end
         // Control word read
         S_FETCH: begin
            if (mem_ack) begin
               next_cw = i_mem_rdata;
               next_caddr = caddr + ADDR_ONE;
               next_state = S_EVAL;
            end else if (!o_mem.req && go) begin
               next_mem.req = 1'b1;
               next_mem.we = 1'b0;
               next_mem.addr = caddr;
            end
         end
         // Decide stop, jump or transfer
         S_EVAL: begin
            if (cw_stop) begin
               next_stop = 1'b1;
               next_engaged = 1'b0;
               next_idle = 1'b1;
               next_grant = '0;
               next_state = S_IDLE;
            end else if (cw_jump) begin
               next_caddr = cw_ptr;
               next_state = S_FETCH;
            end else begin
               next_wc = cw_wc;
               next_out = eff_out;
               next_skip = cw_zptr && !eff_out;
               // Outbound with zero pointer reads from zero
               next_addr = cw_zptr ? ADDR_ZERO : cw_ptr + ADDR_ONE;
               next_state = S_WAITDEV;
            end
         end
         // One device pulse paces each word
         S_WAITDEV: begin
            if (eff_strobe) begin
               next_data = eff_data;
               if (skip) begin
                  next_wc = wc + ADDR_ONE;
                  next_addr = addr + ADDR_ONE;
                  next_state = wc_last ? S_FETCH : S_WAITDEV;
               end else begin
                  next_state = S_MEMCYC;
               end
            end
         end
         // Data word memory cycle
         S_MEMCYC: begin
            if (mem_ack) begin
               if (out_q) begin
                  next_dword = i_mem_rdata;
                  next_dvalid = 1'b1;
               end
               next_wc = wc + ADDR_ONE;
               next_addr = addr + ADDR_ONE;
               next_state = wc_last ? S_FETCH : S_WAITDEV;
            end else if (!o_mem.req && go) begin
               next_mem.req = 1'b1;
               next_mem.we = !out_q;
               next_mem.addr = addr;
               next_mem.wdata = data_q;
               next_mem.par = wpar;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      // Clear abandons everything, even a memory cycle in flight
      if (clr) begin
         next_state = S_IDLE;
         next_mem.req = 1'b0;
         next_engaged = 1'b0;
         next_idle = 1'b1;
         next_grant = '0;
         next_stop = 1'b0;
         next_dvalid = 1'b0;
      end
   end

   // Test mode run flag; a new press beats a same-cycle stop
   always_comb begin
      next_run = run;
      if (!offline || halt_btn) begin
         next_run = 1'b0;
      end else if (mem_ack && sstep) begin
         next_run = 1'b0;
      end
      if (offline && start_btn) begin
         next_run = 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Sequencer and output registers

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= S_IDLE;
         o_mem <= '0;
         o_channel_engaged <= 1'b0;
         o_idle <= 1'b1;
         o_stop <= 1'b0;
         o_grant <= '0;
         o_dev_word_valid <= 1'b0;
         run <= 1'b0;
      end else begin
         state <= next_state;
         o_mem <= next_mem;
         o_channel_engaged <= next_engaged;
         o_idle <= next_idle;
         o_stop <= next_stop;
         o_grant <= next_grant;
         o_dev_word_valid <= next_dvalid;
         run <= next_run;
      end
   end

   // Data path registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         caddr <= '0;
         wc <= '0;
         addr <= '0;
         cw <= '0;
         data_q <= '0;
         skip <= 1'b0;
         out_q <= 1'b0;
         o_dev_word <= '0;
      end else begin
         caddr <= next_caddr;
         wc <= next_wc;
         addr <= next_addr;
         cw <= next_cw;
         data_q <= next_data;
         skip <= next_skip;
         out_q <= next_out;
         o_dev_word <= next_dword;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Delayed clear timer, started with the channel in test mode

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || dclr_exp || !offline) begin
         dclr_run <= 1'b0;
         dclr_cnt <= '0;
      end else if (start_btn && dclr_en) begin
         dclr_run <= 1'b1;
         dclr_cnt <= '0;
      end else if (dclr_run) begin
         dclr_cnt <= dclr_cnt + 32'h0000_0001;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Register port: switches written, state read one cycle later

   wire [CLDC_RW-1:0] status = {9'h000, dclr_run, out_q, skip, run,
      o_channel_engaged, o_idle, state};
   wire [CLDC_RW-1:0] rd_mux =
      (i_reg_addr == REG_CTRL) ? {13'h0000, ctrl} :
      (i_reg_addr == REG_STATUS) ? status :
      (i_reg_addr == REG_CADDR) ? caddr :
      (i_reg_addr == REG_WCOUNT) ? wc :
      (i_reg_addr == REG_XPTR) ? addr : '0;

   // Switch register and read data; data stand one cycle only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ctrl <= CTRL_RST;
         o_reg_rdata <= '0;
      end else begin
         if (ctrl_wr) begin
            ctrl <= i_reg_wdata[CTRL_W-1:0];
         end
         o_reg_rdata <= i_reg_rd ? rd_mux : '0;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   stop_ends_a: assert property ((state == S_EVAL) && cw_stop && !clr |=>
      o_stop && o_idle && !o_channel_engaged && (o_grant == '0) && (state == S_IDLE))
      else $error("stop word did not end the channel");
   fetch_incr_a: assert property ((state == S_FETCH) && mem_ack && !clr |=>
      (caddr == $past(caddr) + ADDR_ONE) && (state == S_EVAL))
      else $error("command address not advanced after fetch");
   jump_load_a: assert property ((state == S_EVAL) && cw_jump && !clr |=>
      (state == S_FETCH) && (caddr == $past(cw_ptr)))
      else $error("jump word not loaded");
   first_ptr_a: assert property ((state == S_EVAL) && !cw_stop && !cw_jump
      && !cw_zptr && !clr |=> (addr == $past(cw_ptr) + ADDR_ONE) && (wc == $past(cw_wc)))
      else $error("transfer pointer not preset to pointer plus one");
   word_step_a: assert property ((state == S_MEMCYC) && mem_ack && !clr |=>
      (wc == $past(wc) + ADDR_ONE) && (addr == $past(addr) + ADDR_ONE))
      else $error("count or pointer not stepped");
   skip_nowrite_a: assert property (skip && (state == S_MEMCYC) |->
      out_q) else $error("discarded block reached memory");
   lockout_par_a: assert property ($rose(o_mem.req) && o_mem.we &&
      $past(lockout) |-> (o_mem.par == ~^o_mem.wdata))
      else $error("even parity written under lockout");
   hold_grant_a: assert property (o_channel_engaged && $past(o_channel_engaged)
      |-> $stable(o_grant)) else $error("grant moved while engaged");
   init_addr_a: assert property ((state == S_INIT) && eff_strobe && !clr |=>
      (caddr == $past(init_addr)) && (state == S_FETCH))
      else $error("start address not taken");
   sstep_halt_a: assert property (offline && sstep && mem_ack && !start_btn
      |=> !run ##1 !$rose(o_mem.req)) else $error("single step ran on");
   clear_a: assert property (clr |=> o_idle && (state == S_IDLE) && !o_mem.req)
      else $error("clear did not idle channel");

   stop_seen_c: cover property (o_channel_engaged ##[1:300] o_stop);
   jump_seen_c: cover property ((state == S_EVAL) && cw_jump);
   skip_block_c: cover property (skip && (state == S_WAITDEV) && eff_strobe);
   dclr_fire_c: cover property (dclr_exp);

endmodule : cldc_channel
